/* File: common/fmc_pkg.sv */
// Package with constants and types for the frequency measure counter.
package fmc_pkg;

   // ----------------------------------------------------------------
   // Widths and sizes
   // ----------------------------------------------------------------
   localparam int CNT_W = 32;
   localparam int FIFO_W = 68;
   localparam int FIFO_DEPTH = 8;
   localparam int NUM_CTR = 4;
   localparam logic [31:0] CNT_MAX = 32'hffffffff;
   localparam logic [31:0] CNT_RST = 32'h00000000;

   // ----------------------------------------------------------------
   // Record layout: {tag[1:0], ovf, err, count_b, count_a}
   // ----------------------------------------------------------------
   localparam int REC_A_LSB = 0;
   localparam int REC_B_LSB = 32;
   localparam int REC_ERR_BIT = 64;
   localparam int REC_OVF_BIT = 65;
   localparam int REC_PAIR_LSB = 66;

   // ----------------------------------------------------------------
   // Measurement modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FMC_MODE_OFF = 3'h0,
      FMC_MODE_HF_PAIR = 3'h1,
      FMC_MODE_HF_EXT = 3'h2,
      FMC_MODE_LARGE = 3'h3,
      FMC_MODE_SINGLE = 3'h4,
      FMC_MODE_SAMPLED = 3'h5
   } fmc_mode_type;

   // ----------------------------------------------------------------
   // Window sequencer states, Gray coded along the usual path
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FMC_ST_IDLE = 2'h0,
      FMC_ST_WAIT = 2'h1,
      FMC_ST_COUNT = 2'h3,
      FMC_ST_DONE = 2'h2
   } fmc_state_type;

endpackage

/* File: hdl/fmc_fifo.sv */
// Record FIFO that buffers measurement results toward the host stream.
`timescale 1ns/10ps
module fmc_fifo
   #(
   parameter int WIDTH = 68,
   parameter int DEPTH = 8
   )
   (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Write side.
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WIDTH-1:0] wr_data_in,
   // Read side.
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out
   );

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic push;
   logic pop;

   // Full when pointers differ only in the wrap bit; empty when equal.
   always_comb
   begin
      wr_ready_out = (wr_ptr[AW] == rd_ptr[AW]) ||
                     (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
      rd_valid_out = (wr_ptr != rd_ptr);
      push = wr_valid_in && wr_ready_out;
      pop = rd_valid_out && rd_ready_in;
      next_wr_ptr = wr_ptr + (AW+1)'(push);
      next_rd_ptr = rd_ptr + (AW+1)'(pop);
      rd_data_out = mem[rd_ptr[AW-1:0]];
   end

   // Pointer registers.
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage array, written without reset.
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= wr_data_in;
      end
   end

endmodule

/* File: hdl/fmc_top.sv */
// Frequency measure counter: two fixed counter pairs and a result FIFO.
//
// Overview of operation
// [RQ1] Counter zero pairs one, two pairs three.
// [RQ2] High frequency: count unknown source inside gate.
// [RQ3] Gate from partner counter or external terminal.
// [RQ4] Large range: even counter makes N-period pulse.
// [RQ5] Even pulse gates odd counter's timebase count.
// [RQ6] Sampled: count unknown and timebase per sample.
// [RQ7] Averaging select chooses mode; averaging default.
// [RQ8] Non-averaging returns last completed unknown period.
// [RQ9] Unknown signal at least twice sample rate.
// [RQ10] Single counter: timebase over one unknown period.
// [RQ11] Divide-down N is a whole integer.
// [RQ12] Count source edges only while gate active.
// [RQ13] No complete pulse between samples flags overrun.
// [RQ14] Counter at maximum flags overflow, no wrap.
`timescale 1ns/10ps
module fmc_top
   import fmc_pkg::*;
   (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // Per-pair configuration, held static while armed.
   input wire logic [1:0] arm_in,
   input wire fmc_mode_type [1:0] mode_in,
   input wire logic [1:0] averaging_disable_in,
   input wire logic [1:0][CNT_W-1:0] divide_n_in,
   input wire logic [1:0][CNT_W-1:0] gate_ticks_in,
   // Asynchronous signal pins.
   input wire logic [1:0] unknown_in,
   input wire logic [1:0] programmable_function_terminal_in,
   input wire logic [1:0] sample_clk_in,
   input wire logic timebase_in,
   // Status.
   output logic [1:0] busy_out,
   output logic [1:0] overrun_out,
   output logic [1:0] overflow_out,
   // Result stream toward host memory.
   output logic stream_valid_out,
   input wire logic stream_ready_in,
   output logic [FIFO_W-1:0] stream_data_out
   );

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NPIN = 7;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1;
   logic [NPIN-1:0] sync2;
   logic [NPIN-1:0] sync3;
   logic [NPIN-1:0] pin_lvl;
   logic [NPIN-1:0] next_pin_lvl;
   logic [NPIN-1:0] pin_prev;

   assign pin_raw = {timebase_in, sample_clk_in,
                     programmable_function_terminal_in, unknown_in};

   // A change is taken once the second and third stages agree.
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
      begin
         next_pin_lvl[i] = (sync2[i] == sync3[i]) ? sync3[i] : pin_lvl[i];
      end
   end

   // Synchroniser and filtered level registers.
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pin_lvl <= '0;
         pin_prev <= '0;
      end
      else
      begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_lvl <= next_pin_lvl;
         pin_prev <= pin_lvl;
      end
   end

   // ----------------------------------------------------------------
   // FIFO write arbitration between the two pairs
   // ----------------------------------------------------------------
   logic [1:0] rec_valid;
   logic [1:0][FIFO_W-1:0] rec_data;
   logic [1:0] rec_take;
   logic fifo_ready;
   logic fifo_wr_valid;
   logic [FIFO_W-1:0] fifo_wr_data;

   // Pair zero has priority; the other waits a cycle.
   always_comb
   begin
      rec_take[0] = rec_valid[0] && fifo_ready;
      rec_take[1] = rec_valid[1] && !rec_valid[0] && fifo_ready;
      fifo_wr_valid = rec_valid[0] || rec_valid[1];
      fifo_wr_data = rec_valid[0] ? rec_data[0] : rec_data[1];
   end

   // ----------------------------------------------------------------
   // Counter pairs: even counter 2p partners odd counter 2p+1
   // ----------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_pair
         fmc_state_type st;
         fmc_state_type next_st;
         logic [CNT_W-1:0] cnt_a;
         logic [CNT_W-1:0] cnt_b;
         logic [CNT_W-1:0] next_cnt_a;
         logic [CNT_W-1:0] next_cnt_b;
         logic [CNT_W-1:0] per_cnt;
         logic [CNT_W-1:0] next_per_cnt;
         logic [CNT_W-1:0] last_per;
         logic [CNT_W-1:0] next_last_per;
         logic got_pulse;
         logic next_got_pulse;
         logic ovf;
         logic next_ovf;
         logic ovr;
         logic next_ovr;
         logic pend;
         logic next_pend;
         logic [FIFO_W-1:0] rec;
         logic [FIFO_W-1:0] next_rec;
         logic ux_rise;
         logic tb_rise;
         logic sc_rise;
         logic pfi_lvl;
         logic gate;

         assign ux_rise = pin_lvl[p] && !pin_prev[p];
         assign pfi_lvl = pin_lvl[2+p];
         assign sc_rise = pin_lvl[4+p] && !pin_prev[4+p];
         assign tb_rise = pin_lvl[6] && !pin_prev[6];
         assign rec_valid[p] = pend;
         assign rec_data[p] = rec;
         assign busy_out[p] = (st != FMC_ST_IDLE);

         // Gate for the active window, per mode.
         always_comb
         begin
            case (mode_in[p])
               FMC_MODE_HF_EXT: gate = pfi_lvl; // RQ3
               default: gate = (st == FMC_ST_COUNT);
            endcase
         end

         // Window sequencing, counting and record building.
         always_comb
         begin
            next_st = st;
            next_cnt_a = cnt_a;
            next_cnt_b = cnt_b;
            next_per_cnt = per_cnt;
            next_last_per = last_per;
            next_got_pulse = got_pulse;
            next_ovf = ovf;
            next_ovr = ovr;
            next_pend = pend && !rec_take[p];
            next_rec = rec;
            case (st)
               FMC_ST_IDLE:
               begin
                  if (arm_in[p] && mode_in[p] != FMC_MODE_OFF)
                  begin
                     next_st = FMC_ST_WAIT;
                     next_cnt_a = CNT_RST;
                     next_cnt_b = CNT_RST;
                     next_per_cnt = CNT_RST;
                     next_got_pulse = 1'b0;
                     next_ovf = 1'b0;
                  end
               end
               FMC_ST_WAIT:
               begin
                  case (mode_in[p])
                     FMC_MODE_HF_EXT:
                        if (!pfi_lvl)
                        begin
                           next_st = FMC_ST_COUNT;
                        end
                     FMC_MODE_SAMPLED:
                        if (sc_rise)
                        begin
                           next_st = FMC_ST_COUNT;
                        end
                     default:
                        if (ux_rise)
                        begin
                           next_st = FMC_ST_COUNT;
                        end
                  endcase
               end
               FMC_ST_COUNT:
               begin
                  // Counters saturate and flag rather than wrap.
                  case (mode_in[p])
                     FMC_MODE_HF_PAIR:
                     begin
                        // Even counter counts unknown in gate; odd times it.
                        if (ux_rise && gate) // RQ2 RQ12
                        begin
                           if (cnt_a == CNT_MAX) next_ovf = 1'b1; // RQ14
                           else next_cnt_a = cnt_a + 1'b1;
                        end
                        next_cnt_b = cnt_b + 1'b1; // RQ1 RQ3
                        if (cnt_b + 1'b1 >= gate_ticks_in[p])
                        begin
                           next_st = FMC_ST_DONE;
                        end
                     end
                     FMC_MODE_HF_EXT:
                     begin
                        if (ux_rise && gate) // RQ2 RQ12
                        begin
                           if (cnt_a == CNT_MAX) next_ovf = 1'b1; // RQ14
                           else next_cnt_a = cnt_a + 1'b1;
                        end
                        if (pfi_lvl && !pin_prev[2+p] && cnt_a != CNT_RST)
                        begin
                           next_st = FMC_ST_DONE;
                        end
                        else if (!pfi_lvl && pin_prev[2+p])
                        begin
                           next_st = FMC_ST_DONE;
                        end
                     end
                     FMC_MODE_LARGE, FMC_MODE_SINGLE:
                     begin
                        // Even counter divides unknown by N; odd times it.
                        if (ux_rise)
                        begin
                           next_cnt_a = cnt_a + 1'b1; // RQ4 RQ11
                           if (mode_in[p] == FMC_MODE_SINGLE ||
                               cnt_a + 1'b1 >= divide_n_in[p])
                           begin
                              next_st = FMC_ST_DONE; // RQ10
                           end
                        end
                        if (tb_rise && gate) // RQ5 RQ12
                        begin
                           if (cnt_b == CNT_MAX) next_ovf = 1'b1; // RQ14
                           else next_cnt_b = cnt_b + 1'b1;
                        end
                     end
                     default:
                     begin
                        // Sampled: T1 unknown ticks, T2 timebase ticks.
                        if (ux_rise)
                        begin
                           if (cnt_a == CNT_MAX) next_ovf = 1'b1; // RQ14
                           else next_cnt_a = cnt_a + 1'b1; // RQ6
                           next_last_per = per_cnt; // RQ8
                           next_per_cnt = CNT_RST;
                           next_got_pulse = got_pulse || (cnt_a != CNT_RST);
                        end
                        if (tb_rise)
                        begin
                           if (cnt_b == CNT_MAX) next_ovf = 1'b1; // RQ14
                           else next_cnt_b = cnt_b + 1'b1; // RQ6
                           if (per_cnt != CNT_MAX && !ux_rise)
                           begin
                              next_per_cnt = per_cnt + 1'b1;
                           end
                        end
                        if (sc_rise)
                        begin
                           next_pend = 1'b1;
                           next_ovr = ovr || !got_pulse; // RQ13 RQ9
                           next_rec[REC_PAIR_LSB +: 2] = 2'(p);
                           // A saturation in the sample cycle still counts.
                           next_rec[REC_OVF_BIT] = next_ovf; // RQ14
                           next_rec[REC_ERR_BIT] = !got_pulse;
                           if (averaging_disable_in[p]) // RQ7
                           begin
                              next_rec[REC_A_LSB +: CNT_W] = CNT_RST + 1'b1;
                              next_rec[REC_B_LSB +: CNT_W] = last_per; // RQ8
                           end
                           else
                           begin
                              next_rec[REC_A_LSB +: CNT_W] = cnt_a;
                              next_rec[REC_B_LSB +: CNT_W] = cnt_b;
                           end
                           next_cnt_a = CNT_RST;
                           next_cnt_b = CNT_RST;
                           next_got_pulse = 1'b0;
                           next_ovf = 1'b0;
                           if (!arm_in[p])
                           begin
                              next_st = FMC_ST_IDLE;
                           end
                        end
                     end
                  endcase
               end
               FMC_ST_DONE:
               begin
                  // Wait for the previous record to drain, then post.
                  if (!pend)
                  begin
                     next_pend = 1'b1;
                     next_rec[REC_PAIR_LSB +: 2] = 2'(p);
                     next_rec[REC_OVF_BIT] = ovf;
                     next_rec[REC_ERR_BIT] = 1'b0;
                     next_rec[REC_A_LSB +: CNT_W] = cnt_a;
                     next_rec[REC_B_LSB +: CNT_W] = cnt_b;
                     next_st = FMC_ST_IDLE;
                  end
               end
               default: next_st = FMC_ST_IDLE;
            endcase
            // Overrun is sticky until rearm; a sample rise with no pulse seen blocks the clear.
            if (st == FMC_ST_IDLE && arm_in[p] && !(sc_rise && !got_pulse))
            begin
               next_ovr = 1'b0;
            end
         end

         // Pair state registers.
         always_ff @(posedge core_clk_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
            begin
               st <= FMC_ST_IDLE;
               cnt_a <= CNT_RST;
               cnt_b <= CNT_RST;
               per_cnt <= CNT_RST;
               last_per <= CNT_RST;
               got_pulse <= 1'b0;
               ovf <= 1'b0;
               ovr <= 1'b0;
               pend <= 1'b0;
               rec <= '0;
            end
            else
            begin
               st <= next_st;
               cnt_a <= next_cnt_a;
               cnt_b <= next_cnt_b;
               per_cnt <= next_per_cnt;
               last_per <= next_last_per;
               got_pulse <= next_got_pulse;
               ovf <= next_ovf;
               ovr <= next_ovr;
               pend <= next_pend;
               rec <= next_rec;
            end
         end

         assign overrun_out[p] = ovr;
         assign overflow_out[p] = ovf;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Result FIFO
   // ----------------------------------------------------------------
   fmc_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .wr_valid_in(fifo_wr_valid),
      .wr_ready_out(fifo_ready),
      .wr_data_in(fifo_wr_data),
      .rd_valid_out(stream_valid_out),
      .rd_ready_in(stream_ready_in),
      .rd_data_out(stream_data_out)
   );

endmodule

/* File: testbench/fmc_top_checker.sv */
// Checker with concurrent properties on the counter's top-level ports.
`timescale 1ns/10ps
module fmc_top_checker
   import fmc_pkg::*;
   (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // Configuration.
   input wire logic [1:0] arm_in,
   input wire fmc_mode_type [1:0] mode_in,
   input wire logic [1:0][CNT_W-1:0] divide_n_in,
   input wire logic [1:0][CNT_W-1:0] gate_ticks_in,
   // Status and stream.
   input wire logic [1:0] busy_out,
   input wire logic [1:0] overrun_out,
   input wire logic [1:0] overflow_out,
   input wire logic stream_valid_out,
   input wire logic stream_ready_in,
   input wire logic [FIFO_W-1:0] stream_data_out
   );
   logic rec0;

   // A pair zero record is offered on the stream.
   assign rec0 = stream_valid_out && stream_data_out[67:66] == 2'h0;

   // Every property samples on the core clock and idles in reset.
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   arm_take_a:
   assert property (arm_in[0] && !busy_out[0] && mode_in[0] != FMC_MODE_OFF
      |=> busy_out[0]) else $error("Arm not taken.");
   rec_push_a:
   assert property ($fell(busy_out[0]) |-> ##[0:2] stream_valid_out)
      else $error("No record after window.");
   rec_hold_a:
   assert property (stream_valid_out && !stream_ready_in
      |=> stream_valid_out && $stable(stream_data_out))
      else $error("Record changed while stalled.");
   ovr_set_a:
   assert property ($rose(overrun_out[0]) |-> mode_in[0] == FMC_MODE_SAMPLED)
      else $error("Overrun outside sampled mode.");
   ovr_clear_a:
   assert property ($fell(overrun_out[0])
      |-> $past(arm_in[0]) && !$past(busy_out[0]))
      else $error("Overrun cleared without arm.");
   ovf_window_a:
   assert property ($rose(overflow_out[0]) |-> $past(busy_out[0]))
      else $error("Overflow outside window.");
   pair_tag_a:
   assert property (stream_valid_out |-> !stream_data_out[67])
      else $error("Bad pair tag.");
   single_a:
   assert property (rec0 && mode_in[0] == FMC_MODE_SINGLE
      |-> stream_data_out[31:0] == 32'h00000001) else $error("Single count.");
   large_n_a:
   assert property (rec0 && mode_in[0] == FMC_MODE_LARGE
      |-> stream_data_out[31:0] == divide_n_in[0]) else $error("Bad N.");
   gate_len_a:
   assert property (rec0 && mode_in[0] == FMC_MODE_HF_PAIR
      |-> stream_data_out[63:32] == gate_ticks_in[0]) else $error("Bad gate.");
endmodule

bind fmc_top fmc_top_checker u_chk (.core_clk_in(core_clk_in),
   .rst_b_in(rst_b_in), .arm_in(arm_in), .mode_in(mode_in),
   .divide_n_in(divide_n_in), .gate_ticks_in(gate_ticks_in),
   .busy_out(busy_out), .overrun_out(overrun_out),
   .overflow_out(overflow_out), .stream_valid_out(stream_valid_out),
   .stream_ready_in(stream_ready_in), .stream_data_out(stream_data_out));

/* File: testbench/fmc_source_model.sv */
// Model of the signal sources and the host stream sink beside the counter.
`timescale 1ns/10ps
module fmc_source_model
   (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Controls from the bench.
   input wire logic [1:0] unk_en_in,
   input wire logic [1:0] smp_en_in,
   input wire logic [1:0] ext_go_in,
   input wire logic [1:0] rdy_mode_in,
   input wire logic rnd_in,
   // Signal pins and stream sink.
   output logic [1:0] unknown_out,
   output logic [1:0] pft_out,
   output logic [1:0] sample_out,
   output logic timebase_out,
   output logic ready_out
   );
   int phase;
   int smp_cnt [2];
   int ext_cnt [2];

   // Phase of the sources, sample interval and external pulse counters.
   always @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         phase <= 0;
         smp_cnt <= '{0, 0};
         ext_cnt <= '{0, 0};
      end
      else
      begin
         phase <= (phase == 39) ? 0 : phase + 1;
         for (int p = 0; p < 2; p++)
         begin
            smp_cnt[p] <= smp_en_in[p] ? smp_cnt[p] + 1 : 0;
            if (!ext_go_in[p])
               ext_cnt[p] <= 0;
            else if (ext_cnt[p] > 0 && ext_cnt[p] < 81)
               ext_cnt[p] <= ext_cnt[p] + 1;
            else if (ext_cnt[p] == 0 && phase == 10)
               ext_cnt[p] <= 1;
         end
      end
   end

   // Unknown rises at phase 0 and the timebase at phase 2, so the two
   // never coincide and counts are exact.
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         unknown_out[p] = unk_en_in[p] && phase < 20;
         sample_out[p] = smp_cnt[p] > 0 && smp_cnt[p] % 200 < 10;
         pft_out[p] = ext_cnt[p] > 0 && ext_cnt[p] < 81;
      end
      timebase_out = phase % 4 >= 2;
      ready_out = rdy_mode_in[1] || (rdy_mode_in[0] && rnd_in);
   end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the frequency measure counter.
`timescale 1ns/10ps
module tb import fmc_pkg::*;;
   typedef struct {
      logic [31:0] a;
      logic [31:0] b;
      int tol;
      logic err;
      logic [1:0] pair;
      bit cnt;
   } fmc_note_type;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] arm = 2'h0;
   fmc_mode_type [1:0] mode;
   logic [1:0] avg_dis = 2'h0;
   logic [1:0][CNT_W-1:0] divn = {32'h00000001, 32'h00000001};
   logic [1:0][CNT_W-1:0] gate = {32'h00000001, 32'h00000190};
   logic [1:0] unk_en = 2'h3;
   logic [1:0] smp_en = 2'h0;
   logic [1:0] ext_go = 2'h0;
   logic [1:0] rdy_mode = 2'h1;
   logic rnd = 1'b0;
   logic [1:0] unk, pft, smp, busy, ovr, ovf;
   logic tbase, rdy, sv;
   logic [FIFO_W-1:0] sd;
   fmc_note_type notes [$];
   int err_count = 0;
   int checks = 0;
   int seed = 82646;

   // Clock and random ready pattern.
   always #2.5 clk = ~clk;
   always @(posedge clk) rnd <= 1'($random(seed));

   fmc_source_model src (.clk_in(clk), .rst_b_in(rst_b), .unk_en_in(unk_en),
      .smp_en_in(smp_en), .ext_go_in(ext_go), .rdy_mode_in(rdy_mode),
      .rnd_in(rnd), .unknown_out(unk), .pft_out(pft), .sample_out(smp),
      .timebase_out(tbase), .ready_out(rdy));

   fmc_top dut (.core_clk_in(clk), .rst_b_in(rst_b), .arm_in(arm),
      .mode_in(mode), .averaging_disable_in(avg_dis), .divide_n_in(divn),
      .gate_ticks_in(gate), .unknown_in(unk),
      .programmable_function_terminal_in(pft), .sample_clk_in(smp),
      .timebase_in(tbase), .busy_out(busy), .overrun_out(ovr),
      .overflow_out(ovf), .stream_valid_out(sv), .stream_ready_in(rdy),
      .stream_data_out(sd));

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic miss(input logic [FIFO_W-1:0] e, input logic [FIFO_W-1:0] g);
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
   endtask

   task automatic cmp_bit(input logic g, input logic e);
      checks++;
      if (g !== e)
         miss({67'h0, e}, {67'h0, g});
   endtask

   // Counts may differ from the note by its tolerance.
   task automatic cmp_rec(input fmc_note_type n, input logic [FIFO_W-1:0] g);
      logic [FIFO_W-1:0] e;
      int da;
      int db;
      e = {n.pair, 1'b0, n.err, n.b, n.a};
      da = int'(g[31:0]) - int'(n.a);
      db = int'(g[63:32]) - int'(n.b);
      checks++;
      if ($isunknown(g) || g[67:64] !== e[67:64] || (n.cnt &&
         (da > n.tol || -da > n.tol || db > n.tol || -db > n.tol)))
         miss(e, g);
   endtask

   function automatic fmc_note_type mk(input int a, input int b, input int t,
      input logic err, input int p, input bit cnt);
      return '{32'(a), 32'(b), t, err, 2'(p), cnt};
   endfunction

   // Takes the oldest note for each record that the sink accepts.
   always @(posedge clk)
   begin
      if (rst_b && sv && rdy)
      begin
         if (notes.size() == 0)
            miss({FIFO_W{1'b0}}, sd);
         else
            cmp_rec(notes.pop_front(), sd);
      end
   end

   task automatic give_up();
      $display("Wait ran out at %0t", $time);
      err_count++;
      summarize();
   endtask

   task automatic wait_busy(input int p, input logic v, input int lim);
      int k;
      for (k = 0; k < lim && busy[p] !== v; k++)
         @(negedge clk);
      if (k == lim)
         give_up();
   endtask

   task automatic drain();
      int k;
      for (k = 0; k < 2000 && notes.size() > 0; k++)
         @(negedge clk);
      if (notes.size() > 0)
         give_up();
   endtask

   task automatic start(input int p, input fmc_mode_type m, input logic ad);
      @(posedge clk);
      mode[p] <= m;
      avg_dis[p] <= ad;
      arm[p] <= 1'b1;
      smp_en[p] <= (m == FMC_MODE_SAMPLED);
      ext_go[p] <= (m == FMC_MODE_HF_EXT);
      wait_busy(p, 1'b1, 20);
      @(posedge clk);
      arm[p] <= 1'b0;
   endtask

   task automatic finish_run(input int p);
      wait_busy(p, 1'b0, 3000);
      @(posedge clk);
      smp_en[p] <= 1'b0;
      ext_go[p] <= 1'b0;
   endtask

   task automatic run(input int p, input fmc_mode_type m, input logic ad);
      start(p, m, ad);
      finish_run(p);
      drain();
      $display("Test mode %s on pair %0d done", m.name(), p);
   endtask

   // Main sequence.
   initial
   begin
      int i;
      int n;
      mode[0] = FMC_MODE_OFF;
      mode[1] = FMC_MODE_OFF;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (100) @(posedge clk);
      notes.push_back(mk(1, 10, 0, 1'b0, 0, 1'b1));
      run(0, FMC_MODE_SINGLE, 1'b0);
      cmp_bit(ovf[0], 1'b0);
      notes.push_back(mk(10, 400, 1, 1'b0, 0, 1'b1));
      run(0, FMC_MODE_HF_PAIR, 1'b0);
      notes.push_back(mk(2, 0, 1, 1'b0, 1, 1'b1));
      run(1, FMC_MODE_HF_EXT, 1'b0);
      for (i = 0; i < 4; i++)
      begin
         n = 1 + ($random(seed) & 3);
         @(posedge clk);
         divn[i % 2] <= 32'(n);
         notes.push_back(mk(n, 10 * n, 1, 1'b0, i % 2, 1'b1));
         run(i % 2, FMC_MODE_LARGE, 1'b0);
      end
      notes.push_back(mk(5, 50, 2, 1'b0, 0, 1'b1));
      run(0, FMC_MODE_SAMPLED, 1'b0);
      notes.push_back(mk(1, 10, 1, 1'b0, 1, 1'b1));
      run(1, FMC_MODE_SAMPLED, 1'b1);
      @(posedge clk);
      unk_en[0] <= 1'b0;
      notes.push_back(mk(0, 0, 0, 1'b1, 0, 1'b0));
      run(0, FMC_MODE_SAMPLED, 1'b0);
      cmp_bit(ovr[0], 1'b1);
      @(posedge clk);
      unk_en[0] <= 1'b1;
      repeat (80) @(posedge clk);
      notes.push_back(mk(1, 10, 0, 1'b0, 0, 1'b1));
      run(0, FMC_MODE_SINGLE, 1'b0);
      cmp_bit(ovr[0], 1'b0);
      @(posedge clk);
      rdy_mode <= 2'h0;
      for (i = 0; i < 10; i++)
      begin
         notes.push_back(mk(1, 10, 0, 1'b0, 0, 1'b1));
         start(0, FMC_MODE_SINGLE, 1'b0);
         if (i < 9)
            finish_run(0);
      end
      repeat (150) @(negedge clk);
      cmp_bit(busy[0], 1'b1);
      cmp_bit(sv, 1'b1);
      @(posedge clk);
      rdy_mode <= 2'h1;
      finish_run(0);
      drain();
      $display("Test full buffer done");
      summarize();
   end
endmodule
